// File: hdl/bce_defines.svh
// Encodings, field positions and reset values for the execute subset
`ifndef BCE_DEFINES_SVH
`define BCE_DEFINES_SVH
`define BCE_OP_NOP 12'h000
`define BCE_OP_OPTLOAD 12'h002
`define BCE_STORE_TOP 7'h01
`define BCE_RET_TOP 4'h8
`define BCE_ROT_TOP 6'h0D
`define BCE_DEST_BIT 5
`define BCE_CARRY_BIT 0
`define BCE_ACC_RST 8'h00
`define BCE_OPT_RST 8'hFF
`define BCE_STATUS_RST 8'h00
`define BCE_PC_RST 9'h000
`endif

// File: hdl/bce_pkg.sv
// Types shared by the execute subset
package bce_pkg;
  typedef enum logic [3:0] {
    BCE_DEC_OTHER = 4'b0001,
    BCE_DEC_STORE = 4'b0010,
    BCE_DEC_RET = 4'b0100,
    BCE_DEC_ROT = 4'b1000
  } bce_dec_t;
  typedef enum logic [1:0] {
    BCE_ST_RUN = 2'b01,
    BCE_ST_FLUSH = 2'b10
  } bce_state_t;
endpackage : bce_pkg

// File: hdl/bce_rotate.sv
// Rotate-left-through-carry datapath
`timescale 1ns/10ps
module bce_rotate (
  // Operand and carry in
  input wire logic [7:0] rot_in,
  input wire logic carry_in,
  // Result and carry out
  output logic [7:0] rot_out,
  output logic carry_out
);
  // Old carry enters bit 0, old bit 7 leaves as carry
  assign rot_out = {rot_in[6:0], carry_in};
  assign carry_out = rot_in[7];
endmodule : bce_rotate

// File: hdl/bce_core.sv
// Decode and execute of store, no-op, option load, literal return, rotate left
//
// Behaviour
// - Store accumulator to file, flags kept
// - Literal return leaves status flags unchanged
// - Literal return loads accumulator with literal
// - Literal return loads program counter from stack
// - Literal return takes two instruction cycles
// - Rotate left through carry at status bit 0
// - Destination bit picks accumulator or file
`timescale 1ns/10ps
`include "bce_defines.svh"
module bce_core import bce_pkg::*; #(
  parameter int PC_W = 9
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Program memory word and stack
  input wire logic [11:0] instr_word,
  input wire logic [PC_W-1:0] top_of_return_stack,
  output logic stack_pop,
  // Data file port
  input wire logic [7:0] file_rdata,
  output logic [4:0] file_addr,
  output logic file_we,
  output logic [7:0] file_wdata,
  // Core state
  output logic [PC_W-1:0] pc_q,
  output logic [7:0] acc_q,
  output logic [7:0] status_q,
  output logic [7:0] option_q,
  output logic busy
);
  // Sequencing state and decoded word
  bce_state_t state_q;
  bce_dec_t dec;
  logic exec;
  logic dest_file;
  logic [7:0] rot_val;
  logic rot_carry;

  // Decode the current word
  always_comb begin
    if (instr_word[11:5] == `BCE_STORE_TOP) begin
      dec = BCE_DEC_STORE;
    end else if (instr_word[11:8] == `BCE_RET_TOP) begin
      dec = BCE_DEC_RET;
    end else if (instr_word[11:6] == `BCE_ROT_TOP) begin
      dec = BCE_DEC_ROT;
    end else begin
      dec = BCE_DEC_OTHER;
    end
  end

  // Execute qualifier and word fields
  assign exec = (state_q == BCE_ST_RUN);
  assign busy = (state_q == BCE_ST_FLUSH); // Second cycle of literal return
  assign dest_file = instr_word[`BCE_DEST_BIT];
  assign file_addr = instr_word[4:0];
  assign stack_pop = exec && (dec == BCE_DEC_RET);

  // Rotate datapath on the addressed file value
  bce_rotate u_rot (
    .rot_in(file_rdata),
    .carry_in(status_q[`BCE_CARRY_BIT]),
    .rot_out(rot_val),
    .carry_out(rot_carry)
  );

  // File write port
  always_comb begin
    file_we = 1'b0;
    file_wdata = acc_q;
    if (exec && dec == BCE_DEC_STORE) begin
      file_we = 1'b1;
    end else if (exec && dec == BCE_DEC_ROT && dest_file) begin
      file_we = 1'b1;
      file_wdata = rot_val;
    end
  end

  // Two-cycle sequencing for literal return
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= BCE_ST_RUN;
    end else begin
      case (state_q)
        BCE_ST_RUN: begin
          if (dec == BCE_DEC_RET) begin
            state_q <= BCE_ST_FLUSH;
          end
        end
        BCE_ST_FLUSH: begin
          state_q <= BCE_ST_RUN;
        end
        default: begin
          state_q <= BCE_ST_RUN;
        end
      endcase
    end
  end

  // Program counter
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pc_q <= PC_W'(`BCE_PC_RST);
    end else if (stack_pop) begin
      pc_q <= top_of_return_stack;
    end else if (exec) begin
      pc_q <= pc_q + 1'b1;
    end
  end

  // Accumulator
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      acc_q <= `BCE_ACC_RST;
    end else if (exec && dec == BCE_DEC_RET) begin
      acc_q <= instr_word[7:0];
    end else if (exec && dec == BCE_DEC_ROT && !dest_file) begin
      acc_q <= rot_val;
    end
  end

  // Status: only rotate touches carry
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status_q <= `BCE_STATUS_RST;
    end else if (exec && dec == BCE_DEC_ROT) begin
      status_q[`BCE_CARRY_BIT] <= rot_carry;
    end
  end

  // Option configuration register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      option_q <= `BCE_OPT_RST;
    end else if (exec && instr_word == `BCE_OP_OPTLOAD) begin
      option_q <= acc_q;
    end
  end

  // Store checks
  a_store_writes: assert property (@(posedge clk_sys) disable iff (rst)
    exec && dec == BCE_DEC_STORE |-> file_we && file_wdata == acc_q)
    else $error("store did not write accumulator");
  a_store_flags: assert property (@(posedge clk_sys) disable iff (rst)
    exec && dec == BCE_DEC_STORE |=> $stable(status_q) && $stable(acc_q))
    else $error("store changed status or accumulator");
  a_store_pc: assert property (@(posedge clk_sys) disable iff (rst)
    exec && dec == BCE_DEC_STORE |=> pc_q == PC_W'($past(pc_q) + 1'b1) && !busy)
    else $error("store not one cycle");

  // Literal return checks
  a_ret_flags: assert property (@(posedge clk_sys) disable iff (rst)
    stack_pop |=> $stable(status_q))
    else $error("literal return changed status");
  a_ret_acc: assert property (@(posedge clk_sys) disable iff (rst)
    stack_pop |=> acc_q == $past(instr_word[7:0]))
    else $error("literal not loaded");
  a_ret_pc: assert property (@(posedge clk_sys) disable iff (rst)
    stack_pop |=> pc_q == $past(top_of_return_stack))
    else $error("pc not loaded from stack");
  a_ret_two: assert property (@(posedge clk_sys) disable iff (rst)
    stack_pop |=> busy ##1 !busy)
    else $error("literal return not two cycles");
  a_ret_no_write: assert property (@(posedge clk_sys) disable iff (rst)
    stack_pop |-> !file_we)
    else $error("literal return wrote the file");
  a_busy_refuse: assert property (@(posedge clk_sys) disable iff (rst)
    busy |-> !file_we && !stack_pop)
    else $error("word executed in flush cycle");
  a_busy_pc_hold: assert property (@(posedge clk_sys) disable iff (rst)
    busy |=> $stable(pc_q) && $stable(acc_q))
    else $error("state moved in flush cycle");
  a_state_onehot: assert property (@(posedge clk_sys) disable iff (rst)
    $onehot(state_q))
    else $error("sequencer state not one-hot");

  // Rotate checks
  a_rot_carry: assert property (@(posedge clk_sys) disable iff (rst)
    exec && dec == BCE_DEC_ROT |=> status_q[0] == $past(file_rdata[7]))
    else $error("rotate carry wrong");
  a_rot_dest: assert property (@(posedge clk_sys) disable iff (rst)
    exec && dec == BCE_DEC_ROT && !dest_file |=> acc_q == $past(rot_val))
    else $error("rotate to accumulator wrong");
  a_rot_shift: assert property (@(posedge clk_sys) disable iff (rst)
    exec && dec == BCE_DEC_ROT && !dest_file |=>
    acc_q == {$past(file_rdata[6:0]), $past(status_q[`BCE_CARRY_BIT])})
    else $error("rotate value wrong");
  a_rot_file: assert property (@(posedge clk_sys) disable iff (rst)
    exec && dec == BCE_DEC_ROT && dest_file |->
    file_we && file_wdata == {file_rdata[6:0], status_q[`BCE_CARRY_BIT]})
    else $error("rotate to file wrong");
  a_rot_other_bits: assert property (@(posedge clk_sys) disable iff (rst)
    exec && dec == BCE_DEC_ROT |=> status_q[7:1] == $past(status_q[7:1]))
    else $error("rotate touched more than carry");
  a_rot_pc: assert property (@(posedge clk_sys) disable iff (rst)
    exec && dec == BCE_DEC_ROT |=> pc_q == PC_W'($past(pc_q) + 1'b1) && !busy)
    else $error("rotate not one cycle");

  // No-op and option checks
  a_nop_still: assert property (@(posedge clk_sys) disable iff (rst)
    exec && instr_word == `BCE_OP_NOP |=> $stable(acc_q) && $stable(status_q))
    else $error("no-op changed state");
  a_nop_file: assert property (@(posedge clk_sys) disable iff (rst)
    exec && instr_word == `BCE_OP_NOP |-> !file_we && !stack_pop)
    else $error("no-op wrote or popped");
  a_nop_pc_step: assert property (@(posedge clk_sys) disable iff (rst)
    exec && instr_word == `BCE_OP_NOP |=> pc_q == PC_W'($past(pc_q) + 1'b1) && !busy)
    else $error("no-op not one cycle");
  a_opt_load: assert property (@(posedge clk_sys) disable iff (rst)
    exec && instr_word == `BCE_OP_OPTLOAD |=> option_q == $past(acc_q))
    else $error("option not loaded");
  a_opt_flags: assert property (@(posedge clk_sys) disable iff (rst)
    exec && instr_word == `BCE_OP_OPTLOAD |=> $stable(status_q) && $stable(acc_q))
    else $error("option load changed status");
  a_opt_kept: assert property (@(posedge clk_sys) disable iff (rst)
    !(exec && instr_word == `BCE_OP_OPTLOAD) |=> $stable(option_q))
    else $error("option changed without load");
endmodule : bce_core

// File: test/bce_file_model.sv
// Data file array behind the core
`timescale 1ns/10ps
module bce_file_model (
  // Clock
  input wire logic clk_sys,
  // File port
  input wire logic [4:0] file_addr,
  input wire logic file_we,
  input wire logic [7:0] file_wdata,
  output logic [7:0] file_rdata
);
  logic [7:0] mem [32];
  // Cleared array, read in the same cycle
  initial foreach (mem[i]) mem[i] = 8'h00;
  assign file_rdata = mem[file_addr];
  // Write lands at the executing edge
  always @(posedge clk_sys) begin
    if (file_we) mem[file_addr] <= file_wdata;
  end
endmodule : bce_file_model

// File: test/tb_top.sv
// Random instruction stream against a reference model
`timescale 1ns/10ps
module tb_top;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [11:0] instr_word = 12'h000;
  logic [8:0] top_of_return_stack = 9'h000;
  logic [8:0] pc_q, e_pc;
  logic [7:0] file_rdata, file_wdata, acc_q, status_q, option_q, r, e_acc, e_opt;
  logic [7:0] sh [32];
  logic [4:0] file_addr, f;
  logic [33:0] notes [$];
  logic file_we, busy, stack_pop, e_c, d;
  int errors = 0;
  int checks = 0;
  int pops = 0;
  int e_pops = 0;
  // Clock
  always #5 clk_sys = ~clk_sys;
  bce_core uut (.clk_sys(clk_sys), .rst(rst), .instr_word(instr_word),
    .top_of_return_stack(top_of_return_stack), .stack_pop(stack_pop), .file_rdata(file_rdata),
    .file_addr(file_addr), .file_we(file_we), .file_wdata(file_wdata), .pc_q(pc_q),
    .acc_q(acc_q), .status_q(status_q), .option_q(option_q), .busy(busy));
  bce_file_model u_file (.clk_sys(clk_sys), .file_addr(file_addr), .file_we(file_we),
    .file_wdata(file_wdata), .file_rdata(file_rdata));
  // Note expected state after the coming edge
  task note(input logic b);
    @(posedge clk_sys);
    #1;
    notes.push_back({b, e_pc, e_acc, 7'h00, e_c, e_opt});
  endtask : note
  task cmp(input logic [33:0] got, input logic [33:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %0t state %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task cmp_pop(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %0t pops %0d expected %0d", $time, got, exp);
    end
  endtask : cmp_pop
  task results;
    if (errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results
  // Settled outputs against the oldest note
  always @(negedge clk_sys) begin
    if (notes.size() > 0) cmp({busy, pc_q, acc_q, status_q, option_q}, notes.pop_front());
  end
  // Count stack pops while each word stands before its edge
  always @(negedge clk_sys) begin
    if (stack_pop) pops++;
  end
  // Reset, then a random mix of the five kinds
  initial begin
    void'($urandom(32'hE80FB68E));
    foreach (sh[i]) sh[i] = 8'h00;
    {e_pc, e_acc, e_c, e_opt} = {9'h000, 8'h00, 1'b0, 8'hFF};
    repeat (5) @(posedge clk_sys);
    note(1'b0);
    rst = 1'b0;
    for (int n = 0; n < 400; n++) begin
      // Mid-run reset on a quiet word
      if (n == 200) begin
        instr_word = 12'h000;
        rst = 1'b1;
        {e_pc, e_acc, e_c, e_opt} = {9'h000, 8'h00, 1'b0, 8'hFF};
        note(1'b0);
        rst = 1'b0;
      end
      f = 5'($urandom);
      d = 1'($urandom);
      top_of_return_stack = 9'($urandom);
      r = {sh[f][6:0], e_c};
      e_pc = e_pc + 9'h001;
      case ($urandom % 5)
        0: instr_word = 12'h000;
        1: begin
          instr_word = 12'h002;
          e_opt = e_acc;
        end
        2: begin
          instr_word = {7'h01, f};
          sh[f] = e_acc;
        end
        3: begin
          r = 8'($urandom);
          e_pops++;
          instr_word = {4'h8, r};
          e_acc = r;
          e_pc = top_of_return_stack;
          note(1'b1);
          instr_word = 12'($urandom);
        end
        default: begin
          instr_word = {6'h0D, d, f};
          e_c = sh[f][7];
          if (d) sh[f] = r;
          else e_acc = r;
        end
      endcase
      note(1'b0);
    end
    instr_word = 12'h000;
    @(negedge clk_sys);
    #1;
    cmp_pop(16'(pops), 16'(e_pops));
    results();
  end
endmodule : tb_top
